// *** lf_tick_gen.sv ***
// Purpose: one-cycle enable at the low-frequency counting rate
// Assumes: single clock, synchronous reset
// Notes:   divide ratio is a parameter
`default_nettype none
module lf_tick_gen #(
    parameter int DIV = wdt_pkg::LF_DIV
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    output logic      tick
);
    logic [15:0] cnt;
    wire         wrap = (cnt == 16'(DIV - 1));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else begin
            cnt  <= wrap ? 16'h0000 : cnt + 16'h0001;
            tick <= wrap;
        end
    end
endmodule : lf_tick_gen
`default_nettype wire

// *** watchdog_reload_control.sv ***
// Purpose: watchdog counter with key-protected reload slots on AHB-Lite
// Assumes: one clock, synchronous active-high reset
// Notes:   counter advances on the low-frequency enable pulse
//
// Decided for this implementation: register access over AHB-Lite.
`default_nettype none
module watchdog_reload_control #(
    parameter logic [31:0] KEY    = wdt_pkg::RELOAD_KEY,
    parameter int          NSLOTS = 8,
    parameter int          LF_DIV = wdt_pkg::LF_DIV
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        cpu_sleeping,
    input  wire logic        cpu_halted,
    input  wire logic        wake_from_off,
    output logic             irq,
    output logic             wdt_reset
);
    ////////////////////////////////////////////////////////////////////////
    // state
    logic [31:0]        counter;
    logic [31:0]        counter_reload_value;
    logic [NSLOTS-1:0]  slot_enable;
    logic [NSLOTS-1:0]  slot_request_state;
    logic               sleep_run;
    logic               halt_run;
    logic               counter_running_flag;
    logic               locked;
    logic               irq_enable;
    logic               expiry_event;
    logic [1:0]         delay_cnt;
    wdt_pkg::seq_e      seq;
    logic [11:0]        dp_addr;
    logic               dp_write;
    logic               dp_read;
    logic               rd_wait;
    logic               lf_tick;

    lf_tick_gen #(
        .DIV     (LF_DIV)
    ) u_tick (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (lf_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    wire        addr_take = hsel & htrans[1] & hready;
    wire        wr_do     = dp_write;
    wire        wr_start  = wr_do & (dp_addr == wdt_pkg::OFF_START);
    wire        wr_expiry = wr_do & (dp_addr == wdt_pkg::OFF_EXPIRY);
    wire        wr_ien    = wr_do & (dp_addr == wdt_pkg::OFF_IRQ_ENABLE);
    wire        wr_idis   = wr_do & (dp_addr == wdt_pkg::OFF_IRQ_DIS);
    wire        wr_crv    = wr_do & (dp_addr == wdt_pkg::OFF_CRV)
                            & ~locked;
    wire        wr_en     = wr_do & (dp_addr == wdt_pkg::OFF_SLOT_EN)
                            & ~locked;
    wire        wr_cfg    = wr_do & (dp_addr == wdt_pkg::OFF_CONFIG)
                            & ~locked;
    wire [11:0] slot_off  = dp_addr - wdt_pkg::OFF_SLOT_BASE;
    wire        in_slots  = (dp_addr >= wdt_pkg::OFF_SLOT_BASE) &&
                            (slot_off < 12'(NSLOTS * wdt_pkg::SLOT_STRIDE));
    wire        key_ok    = wr_do & in_slots & (slot_off[1:0] == 2'h0)
                            & (hwdata == KEY);
    wire [2:0]  slot_idx  = slot_off[4:2];

    ////////////////////////////////////////////////////////////////////////
    // counter control
    wire paused     = (cpu_sleeping & ~sleep_run)
                    | (cpu_halted & ~halt_run);
    wire count_step = counter_running_flag & lf_tick & ~paused;
    wire expire     = count_step & (counter == 32'h00000001)
                    & (seq == wdt_pkg::SEQ_IDLE);
    wire start_go   = wr_start & hwdata[0] & ~counter_running_flag;

    logic [NSLOTS-1:0] slot_hit;
    genvar g;
    generate
        for (g = 0; g < NSLOTS; g++) begin : g_slot
            assign slot_hit[g] = key_ok & (slot_idx == 3'(g));
        end
    endgenerate

    wire [NSLOTS-1:0] next_req_raw = slot_request_state & ~slot_hit;
    wire              all_done     = counter_running_flag
                                   & (|slot_enable)
                                   & ((next_req_raw & slot_enable) == '0);

    ////////////////////////////////////////////////////////////////////////
    // read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        case (dp_addr)
            wdt_pkg::OFF_EXPIRY:     rd_mux = {31'h0, expiry_event};
            wdt_pkg::OFF_IRQ_ENABLE: rd_mux = {31'h0, irq_enable};
            wdt_pkg::OFF_IRQ_DIS:    rd_mux = {31'h0, irq_enable};
            wdt_pkg::OFF_RUN:
                rd_mux = {31'h0, counter_running_flag};
            wdt_pkg::OFF_REQ:
                rd_mux = 32'(slot_request_state & slot_enable);
            wdt_pkg::OFF_CRV:        rd_mux = counter_reload_value;
            wdt_pkg::OFF_SLOT_EN:    rd_mux = 32'(slot_enable);
            wdt_pkg::OFF_CONFIG: begin
                rd_mux[wdt_pkg::CFG_SLEEP_BIT] = sleep_run;
                rd_mux[wdt_pkg::CFG_HALT_BIT]  = halt_run;
            end
            default:                 rd_mux = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // ahb-lite slave: writes zero-wait, reads one wait state
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dp_addr   <= 12'h000;
            dp_write  <= 1'b0;
            dp_read   <= 1'b0;
            rd_wait   <= 1'b0;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (dp_read && !rd_wait) begin
                hrdata    <= rd_mux;
                rd_wait   <= 1'b1;
                hreadyout <= 1'b1;
                dp_read   <= 1'b0;
            end else begin
                rd_wait   <= 1'b0;
                dp_addr   <= addr_take ? haddr[11:0] : dp_addr;
                dp_write  <= addr_take & hwrite;
                dp_read   <= addr_take & ~hwrite;
                hreadyout <= ~(addr_take & ~hwrite);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            counter_reload_value <= wdt_pkg::CRV_RESET;
            slot_enable          <= NSLOTS'(wdt_pkg::SLOT_EN_RESET);
            sleep_run <= wdt_pkg::CONFIG_RESET[wdt_pkg::CFG_SLEEP_BIT];
            halt_run  <= wdt_pkg::CONFIG_RESET[wdt_pkg::CFG_HALT_BIT];
            irq_enable           <= 1'b0;
        end else begin
            if (wr_crv)
                counter_reload_value <= hwdata;
            if (wr_en)
                slot_enable <= hwdata[NSLOTS-1:0];
            if (wr_cfg) begin
                sleep_run <= hwdata[wdt_pkg::CFG_SLEEP_BIT];
                halt_run  <= hwdata[wdt_pkg::CFG_HALT_BIT];
            end
            if (wr_idis && hwdata[0])
                irq_enable <= 1'b0;
            else if (wr_ien && hwdata[0])
                irq_enable <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter, lock and slot bookkeeping
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            counter              <= wdt_pkg::CRV_RESET;
            counter_running_flag <= 1'b0;
            locked               <= 1'b0;
            slot_request_state   <= NSLOTS'(wdt_pkg::SLOT_EN_RESET);
        end else begin
            if (start_go) begin
                counter_running_flag <= 1'b1;
                locked               <= 1'b1;
                counter              <= counter_reload_value;
                slot_request_state   <= slot_enable;
            end else if (counter_running_flag) begin
                if (all_done) begin
                    counter            <= counter_reload_value;
                    slot_request_state <= slot_enable;
                end else begin
                    slot_request_state <= next_req_raw;
                    if (count_step && counter != 32'h00000000)
                        counter <= counter - 32'h00000001;
                end
            end else begin
                slot_request_state <= slot_enable;
            end
            if (wake_from_off)
                locked <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // expiry event and reset sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            expiry_event <= 1'b0;
            seq          <= wdt_pkg::SEQ_IDLE;
            delay_cnt    <= 2'h0;
            wdt_reset    <= 1'b0;
            irq          <= 1'b0;
        end else begin
            if (expire)
                expiry_event <= 1'b1;
            else if (wr_expiry && hwdata[0])
                expiry_event <= 1'b0;
            irq <= (expiry_event | expire) & irq_enable;
            case (seq)
                wdt_pkg::SEQ_IDLE: begin
                    if (expire) begin
                        delay_cnt <= 2'h0;
                        seq <= irq_enable ? wdt_pkg::SEQ_DELAY
                                          : wdt_pkg::SEQ_FIRE;
                    end
                end
                wdt_pkg::SEQ_DELAY: begin
                    if (lf_tick)
                        delay_cnt <= delay_cnt + 2'h1;
                    if (lf_tick &&
                        delay_cnt == wdt_pkg::EXPIRY_DELAY_TICKS - 2'h1)
                        seq <= wdt_pkg::SEQ_FIRE;
                end
                wdt_pkg::SEQ_FIRE: begin
                    wdt_reset <= 1'b1;
                end
                default: seq <= wdt_pkg::SEQ_IDLE;
            endcase
        end
    end
endmodule : watchdog_reload_control
`default_nettype wire

// *** watchdog_reload_control_asserts.sv ***
// Purpose: port-level checks of the watchdog reload control block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the design below
`default_nettype none
module watchdog_reload_control_asserts (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic        wdt_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    sequence s_rd;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_wr;
        hsel && htrans[1] && hready && hwrite;
    endsequence
    sequence s_dis;
        s_wr ##0 (haddr[11:0] == wdt_pkg::OFF_IRQ_DIS) ##1 hwdata[0];
    endsequence
    ////////////////////////////////////////////////////////////////////////
    property p_rd_wait;
        s_rd |=> !hreadyout ##1 hreadyout;
    endproperty
    property p_wr_nowait;
        s_wr |=> hreadyout;
    endproperty
    property p_ready_one;
        !hreadyout |=> hreadyout;
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    property p_irq_dis;
        s_dis |=> ##1 !irq;
    endproperty
    property p_reset_holds;
        wdt_reset |=> wdt_reset;
    endproperty
    property p_irq_to_reset;
        $rose(irq) |-> ##[1:40] wdt_reset;
    endproperty
    property p_reset_waits;
        $rose(irq) && !wdt_reset |-> !wdt_reset [*4];
    endproperty
    a_rd_wait: assert property (p_rd_wait)
        else $error("read data phase not one wait cycle");
    a_wr_nowait: assert property (p_wr_nowait)
        else $error("write data phase stalled");
    a_ready_one: assert property (p_ready_one)
        else $error("ready low for more than one cycle");
    a_okay: assert property (p_okay)
        else $error("response not okay");
    a_irq_dis: assert property (p_irq_dis)
        else $error("irq still high after disable write");
    a_reset_holds: assert property (p_reset_holds)
        else $error("watchdog reset dropped");
    a_irq_to_reset: assert property (p_irq_to_reset)
        else $error("no watchdog reset after expiry");
    a_reset_waits: assert property (p_reset_waits)
        else $error("watchdog reset not delayed");
endmodule : watchdog_reload_control_asserts
bind watchdog_reload_control watchdog_reload_control_asserts u_chk (
    .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .wdt_reset(wdt_reset));
`default_nettype wire

// *** watchdog_reload_control_tb.sv ***
// Purpose: self-checking bench of the watchdog reload control block
// Assumes: ahb-lite single word transfers, short divide ratio
// Notes:   register sequences with expected values
`default_nettype none
module watchdog_reload_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, sys_rst, hsel, hwrite, hready, hreadyout, hresp;
    logic        cpu_sleeping, cpu_halted, wake_from_off, irq, wdt_reset;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    int          mismatches, n_tests, cycles, i;
    assign hready = hreadyout;
    watchdog_reload_control #(.LF_DIV(4)) DUT (
        .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .cpu_sleeping(cpu_sleeping), .cpu_halted(cpu_halted),
        .wake_from_off(wake_from_off), .irq(irq), .wdt_reset(wdt_reset));
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h00000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000);
        chk(q, exp);
    endtask : rc
    task automatic do_reset;
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            close_out();
        end
    end
    initial begin
        {sys_rst, hsel, hwrite, cpu_sleeping, cpu_halted} = 5'h10;
        {wake_from_off, htrans, haddr, hwdata} = '0;
        do_reset();
        rc(wdt_pkg::OFF_RUN, 32'h00000000);
        rc(wdt_pkg::OFF_REQ, 32'h00000001);
        rc(wdt_pkg::OFF_SLOT_EN, 32'h00000001);
        rc(wdt_pkg::OFF_CONFIG, 32'h00000001);
        rc(wdt_pkg::OFF_IRQ_DIS, 32'h00000000);
        rc(12'h7F0, 32'h00000000);
        xfer(1'b1, wdt_pkg::OFF_SLOT_EN, 32'h000000FF);
        rc(wdt_pkg::OFF_REQ, 32'h000000FF);
        xfer(1'b1, wdt_pkg::OFF_CONFIG, 32'h00000008);
        rc(wdt_pkg::OFF_CONFIG, 32'h00000008);
        xfer(1'b1, wdt_pkg::OFF_CRV, 32'h00000028);
        xfer(1'b1, wdt_pkg::OFF_IRQ_ENABLE, 32'h00000001);
        xfer(1'b1, wdt_pkg::OFF_IRQ_DIS, 32'h00000000);
        rc(wdt_pkg::OFF_IRQ_DIS, 32'h00000001);
        xfer(1'b1, wdt_pkg::OFF_START, 32'h00000001);
        rc(wdt_pkg::OFF_RUN, 32'h00000001);
        xfer(1'b1, wdt_pkg::OFF_SLOT_EN, 32'h00000001);
        rc(wdt_pkg::OFF_SLOT_EN, 32'h000000FF);
        xfer(1'b1, wdt_pkg::OFF_SLOT_BASE, wdt_pkg::RELOAD_KEY ^ 32'h1);
        rc(wdt_pkg::OFF_REQ, 32'h000000FF);
        for (i = 0; i < 7; i++)
            xfer(1'b1, wdt_pkg::OFF_SLOT_BASE + 12'(4 * i),
                 wdt_pkg::RELOAD_KEY);
        rc(wdt_pkg::OFF_REQ, 32'h00000080);
        xfer(1'b1, wdt_pkg::OFF_SLOT_BASE + 12'h01C, wdt_pkg::RELOAD_KEY);
        rc(wdt_pkg::OFF_REQ, 32'h000000FF);
        cpu_sleeping <= 1'b1;
        repeat (250) @(posedge clk);
        chk({31'h0, irq}, 32'h00000000);
        cpu_sleeping <= 1'b0;
        cpu_halted   <= 1'b1;
        for (i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001);
        chk({31'h0, wdt_reset}, 32'h00000000);
        for (i = 0; i < 40 && wdt_reset !== 1'b1; i++) @(posedge clk);
        chk({31'h0, wdt_reset}, 32'h00000001);
        xfer(1'b1, wdt_pkg::OFF_EXPIRY, 32'h00000001);
        rc(wdt_pkg::OFF_EXPIRY, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        xfer(1'b1, wdt_pkg::OFF_IRQ_DIS, 32'h00000001);
        rc(wdt_pkg::OFF_IRQ_DIS, 32'h00000000);
        cpu_halted <= 1'b0;
        do_reset();
        chk({31'h0, wdt_reset}, 32'h00000000);
        xfer(1'b1, wdt_pkg::OFF_START, 32'h00000001);
        xfer(1'b1, wdt_pkg::OFF_SLOT_EN, 32'h00000003);
        rc(wdt_pkg::OFF_SLOT_EN, 32'h00000001);
        wake_from_off <= 1'b1;
        @(posedge clk);
        wake_from_off <= 1'b0;
        xfer(1'b1, wdt_pkg::OFF_SLOT_EN, 32'h00000003);
        rc(wdt_pkg::OFF_SLOT_EN, 32'h00000003);
        close_out();
    end
endmodule : watchdog_reload_control_tb
`default_nettype wire

// *** wdt_pkg.sv ***
// Purpose: shared constants of the watchdog reload control block
// Assumes: 32-bit AHB-Lite register window, word aligned
// Notes:   offsets are byte addresses
`default_nettype none
package wdt_pkg;
    localparam logic [11:0] OFF_START      = 12'h000;
    localparam logic [11:0] OFF_EXPIRY     = 12'h100;
    localparam logic [11:0] OFF_IRQ_ENABLE = 12'h304;
    localparam logic [11:0] OFF_IRQ_DIS    = 12'h308;
    localparam logic [11:0] OFF_RUN        = 12'h400;
    localparam logic [11:0] OFF_REQ        = 12'h404;
    localparam logic [11:0] OFF_CRV        = 12'h504;
    localparam logic [11:0] OFF_SLOT_EN    = 12'h508;
    localparam logic [11:0] OFF_CONFIG     = 12'h50C;
    localparam logic [11:0] OFF_SLOT_BASE  = 12'h600;
    localparam int          SLOT_STRIDE    = 4;
    localparam int          CFG_SLEEP_BIT  = 0;
    localparam int          CFG_HALT_BIT   = 3;
    localparam logic [31:0] CRV_RESET      = 32'hFFFFFFFF;
    localparam logic [7:0]  SLOT_EN_RESET  = 8'h01;
    localparam logic [31:0] CONFIG_RESET   = 32'h00000001;
    // arbitrary key value
    localparam logic [31:0] RELOAD_KEY     = 32'hC0DE5A17;
    localparam int          CLK_HZ         = 125_000_000;
    localparam int          LF_HZ          = 32_768;
    localparam int          LF_DIV         = CLK_HZ / LF_HZ;
    localparam logic [1:0]  EXPIRY_DELAY_TICKS = 2'h2;
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_DELAY,
        SEQ_FIRE
    } seq_e;
endpackage : wdt_pkg
`default_nettype wire
